// File: pkg/reset_seq_pkg.sv
// How it works
// - three reset copies, immediate assert, synchronized release
// - reset holds link resets, floats config bus
// - returned reset releases on a clock edge
// - internal reset releases five cycles after module reset
// - latch straps: fill and extract delays
// - latch straps: link presets per CPU, spare
// - latch straps: base data-path configuration
// - boot ROM enable gives two-cycle link-reset pulse
// - system reset resets link interfaces asynchronously
// - links in reset neither count nor send clocks
// - enable release queues toggle command, first idle cycle
// - CPU link reset drops one cycle after command
// - own receiver release waits data-path decode latency
// - align to frame, receive, transmit four cycles later
// - simultaneous toggles: CPU 0 before CPU 1
// - in reset: byte masks high, no-op command
// - precharge all on release, refresh off
// - mode-program write sends mode set with value
package reset_seq_pkg;
   localparam int NUM_CPU = 2;
   localparam int NUM_ARRAY = 4;
   localparam int SYNC_STAGES = 2;
   localparam int DIST_STAGES = 2;
   localparam int MODRST_MIN_US = 200;
   localparam int CLK_MHZ = 50;
   localparam int MODRST_MIN_CYC = MODRST_MIN_US * CLK_MHZ;
   localparam logic [3:0] NOTIFY_PULSE_CYC = 4'h2;
   localparam logic [3:0] DP_DECODE_LAT = 4'h2;
   localparam logic [3:0] TX_START_CYC = 4'h4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SD_ADDR_W = 14;
   localparam logic [ADDR_W-1:0] REG_STRAP = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LINK = 8'h04;
   localparam logic [ADDR_W-1:0] REG_MEM_TIMING = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CFG_DRIVE = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_MODE_PROG0 = 8'h10;
   localparam int MODE_IDX_LSB = 2;
   localparam int CFG_DRIVE_EN_BIT = 8;
   localparam int STRAP_SPARE = 7;
   localparam int STRAP_FILL = 6;
   localparam int STRAP_EXTR_LSB = 4;
   localparam int STRAP_PRESET1 = 3;
   localparam int STRAP_PRESET0 = 2;
   localparam int STRAP_BASE_LSB = 0;
   localparam logic [1:0] FILL_BASE_CYC = 2'h2;
   localparam logic [2:0] EXTR_BASE_CYC = 3'h2;
   localparam int REF_SHIFT = 4;
   localparam int PCHG_ADDR_BIT = 10;
   localparam logic [2:0] SD_NOP = 3'h7;
   localparam logic [2:0] SD_PRECHARGE = 3'h2;
   localparam logic [2:0] SD_REFRESH = 3'h1;
   localparam logic [2:0] SD_MODE_SET = 3'h0;
   localparam logic [1:0] DP_CMD_IDLE = 2'h0;
   localparam logic [1:0] DP_CMD_TOGGLE_LINK = 2'h1;
   typedef enum logic [2:0] {
      LK_HELD = 3'b000,
      LK_NOTIFY = 3'b001,
      LK_LOADING = 3'b010,
      LK_ISSUE = 3'b011,
      LK_SENT = 3'b100,
      LK_RUN = 3'b101
   } link_state_t;
endpackage : reset_seq_pkg

// File: core/reset_init_seq.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_init_seq (
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic sysRstA_n,
   output logic sysRstB_n,
   output logic sysRstC_n,
   output logic sysRstInt_n,
   input wire logic [7:0] cfgBusDataIn,
   output logic [7:0] cfgBusDataOut,
   output logic cfgBusDataOe,
   output logic fillDelay,
   output logic [1:0] fillDelayCyc,
   output logic [2:0] extractDelayCyc,
   output logic [reset_seq_pkg::NUM_CPU-1:0] linkPreset,
   output logic [1:0] baseConfig,
   output logic moduleSpare,
   input wire logic [reset_seq_pkg::NUM_CPU-1:0] bootRomEn_n,
   output logic [reset_seq_pkg::NUM_CPU-1:0] linkRst,
   input wire logic frameTick,
   output logic [reset_seq_pkg::NUM_CPU-1:0] rxLinkRst,
   output logic [reset_seq_pkg::NUM_CPU-1:0] rxCountEn,
   output logic [reset_seq_pkg::NUM_CPU-1:0] txClkEn,
   input wire logic dpBusBusy,
   output logic dpCmdValid,
   output logic [1:0] dpCmd,
   output logic dpCmdCpu,
   output logic [2:0] sdramCmd,
   output logic [reset_seq_pkg::NUM_ARRAY-1:0] sdramSel,
   output logic [reset_seq_pkg::SD_ADDR_W-1:0] sdramAddr,
   output logic [1:0] sdramDqm,
   input wire logic [reset_seq_pkg::ADDR_W-1:0] regAddr,
   input wire logic [reset_seq_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [reset_seq_pkg::DATA_W-1:0] regRdData
);
   import reset_seq_pkg::*;

   logic [SYNC_STAGES-1:0] sync_r;
   logic [2:0] copy_r;
   logic [DIST_STAGES-1:0] dist_r;
   logic strapDone_r;
   logic [7:0] strap_r;
   logic [7:0] cfgOut_r;
   logic cfgOe_r;
   link_state_t state_r [NUM_CPU];
   link_state_t state_nxt [NUM_CPU];
   logic [3:0] pulseCnt_r [NUM_CPU];
   logic [NUM_CPU-1:0] romEnPrev_r;
   logic [NUM_CPU-1:0] linkRst_r;
   logic [NUM_CPU-1:0] grant;
   logic [3:0] rxCnt_r [NUM_CPU];
   logic [NUM_CPU-1:0] rxWait_r;
   logic [NUM_CPU-1:0] rxRstOff_r;
   logic [NUM_CPU-1:0] rxEn_r;
   logic [3:0] txCnt_r [NUM_CPU];
   logic [NUM_CPU-1:0] txEn_r;
   logic dpValid_r;
   logic [1:0] dpCmd_r;
   logic dpCpu_r;
   logic [7:0] refInterval_r;
   logic [11:0] refCnt_r;
   logic [11:0] refLimit;
   logic refPend_r;
   logic pchgDone_r;
   logic [NUM_ARRAY-1:0] mrsPend_r;
   logic [SD_ADDR_W-1:0] modeVal_r [NUM_ARRAY];
   logic [2:0] sdCmd_r;
   logic [NUM_ARRAY-1:0] sdSel_r;
   logic [SD_ADDR_W-1:0] sdAddr_r;
   logic [1:0] sdDqm_r;
   logic [DATA_W-1:0] rdData_r;
   logic modeHit;
   logic [1:0] modeIdx;
   logic [1:0] mrsIdx;
   logic mrsAny;

   // module reset must already be held long enough by the board
   // synchronizer: async assert, clocked release; first stage feeds only the second
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_r <= '0;
      end else begin
         sync_r <= {sync_r[SYNC_STAGES-2:0], 1'b1};
      end
   end

   // three separate copies so each net has its own driver
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         copy_r <= '0;
      end else begin
         copy_r <= {3{sync_r[SYNC_STAGES-1]}};
      end
   end

   // returned copy runs the same distribution delay as the other chips see
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dist_r <= '0;
      end else begin
         dist_r <= {dist_r[DIST_STAGES-2:0], copy_r[0]};
      end
   end

   assign sysRstA_n = copy_r[0];
   assign sysRstB_n = copy_r[1];
   assign sysRstC_n = copy_r[2];
   assign sysRstInt_n = dist_r[DIST_STAGES-1];

   // straps are caught on the first edge after release, never in the reset branch
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         strapDone_r <= 1'b0;
         strap_r <= 8'h00;
      end else if (!strapDone_r) begin
         strapDone_r <= 1'b1;
         strap_r <= cfgBusDataIn;
      end
   end

   assign fillDelay = strap_r[STRAP_FILL];
   assign fillDelayCyc = FILL_BASE_CYC + {1'b0, strap_r[STRAP_FILL]};
   assign extractDelayCyc = EXTR_BASE_CYC + {1'b0, strap_r[STRAP_EXTR_LSB +: 2]};
   assign linkPreset = {strap_r[STRAP_PRESET1], strap_r[STRAP_PRESET0]};
   assign moduleSpare = strap_r[STRAP_SPARE];
   assign baseConfig = strap_r[STRAP_BASE_LSB +: 2];

   // the config bus floats through reset so the straps set its levels
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         cfgOut_r <= 8'h00;
         cfgOe_r <= 1'b0;
      end else if (regWr && regAddr == REG_CFG_DRIVE) begin
         cfgOut_r <= regWrData[7:0];
         cfgOe_r <= regWrData[CFG_DRIVE_EN_BIT];
      end
   end

   assign cfgBusDataOut = cfgOut_r;
   assign cfgBusDataOe = cfgOe_r;

   // fixed priority: CPU 0 wins a tie, and only when the command bus is idle
   always_comb begin
      grant = '0;
      if (!dpBusBusy) begin
         if (state_r[0] == LK_ISSUE) begin
            grant[0] = 1'b1;
         end else if (state_r[1] == LK_ISSUE) begin
            grant[1] = 1'b1;
         end
      end
   end

   genvar c;
   generate
      for (c = 0; c < NUM_CPU; c++) begin : g_cpu
         // the CPU raises enable when ready and drops it after its load
         always_comb begin
            state_nxt[c] = state_r[c];
            unique case (state_r[c])
               LK_HELD: begin
                  if (!bootRomEn_n[c] && romEnPrev_r[c]) begin
                     state_nxt[c] = LK_NOTIFY;
                  end
               end
               LK_NOTIFY: begin
                  if (pulseCnt_r[c] == 4'h1) begin
                     state_nxt[c] = LK_LOADING;
                  end
               end
               LK_LOADING: begin
                  if (bootRomEn_n[c] && !romEnPrev_r[c]) begin
                     state_nxt[c] = LK_ISSUE;
                  end
               end
               LK_ISSUE: begin
                  if (grant[c]) begin
                     state_nxt[c] = LK_SENT;
                  end
               end
               LK_SENT: begin
                  state_nxt[c] = LK_RUN;
               end
               LK_RUN: begin
                  state_nxt[c] = LK_RUN;
               end
               default: begin
                  state_nxt[c] = LK_HELD;
               end
            endcase
         end

         always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
            if (!sysRstInt_n) begin
               state_r[c] <= LK_HELD;
               romEnPrev_r[c] <= 1'b1;
               pulseCnt_r[c] <= 4'h0;
            end else begin
               state_r[c] <= state_nxt[c];
               romEnPrev_r[c] <= bootRomEn_n[c];
               if (state_nxt[c] == LK_NOTIFY && state_r[c] != LK_NOTIFY) begin
                  pulseCnt_r[c] <= NOTIFY_PULSE_CYC;
               end else if (pulseCnt_r[c] != 4'h0) begin
                  pulseCnt_r[c] <= pulseCnt_r[c] - 4'h1;
               end
            end
         end

         // link reset held by system reset; notify is a two-cycle release notch
         always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
            if (!sysRstInt_n) begin
               linkRst_r[c] <= 1'b1;
            end else begin
               linkRst_r[c] <= !(state_nxt[c] == LK_RUN || state_nxt[c] == LK_NOTIFY);
            end
         end

         // own receiver waits the far decode path, then frame-aligns
         always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
            if (!sysRstInt_n) begin
               rxCnt_r[c] <= 4'h0;
               rxWait_r[c] <= 1'b0;
               rxRstOff_r[c] <= 1'b0;
            end else if (grant[c]) begin
               rxCnt_r[c] <= DP_DECODE_LAT;
               rxWait_r[c] <= 1'b1;
            end else if (rxWait_r[c]) begin
               if (rxCnt_r[c] == 4'h1) begin
                  rxWait_r[c] <= 1'b0;
                  rxRstOff_r[c] <= 1'b1;
               end else begin
                  rxCnt_r[c] <= rxCnt_r[c] - 4'h1;
               end
            end
         end

         // receive only after a frame edge; transmit clocks four cycles on
         always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
            if (!sysRstInt_n) begin
               rxEn_r[c] <= 1'b0;
               txEn_r[c] <= 1'b0;
               txCnt_r[c] <= 4'h0;
            end else if (rxRstOff_r[c] && !rxEn_r[c] && frameTick) begin
               rxEn_r[c] <= 1'b1;
               txCnt_r[c] <= TX_START_CYC;
            end else if (rxEn_r[c] && !txEn_r[c]) begin
               if (txCnt_r[c] == 4'h1) begin
                  txEn_r[c] <= 1'b1;
               end else begin
                  txCnt_r[c] <= txCnt_r[c] - 4'h1;
               end
            end
         end
      end
   endgenerate

   // CPU link comes up three cycles after release; ours is already out by then
   assign linkRst = linkRst_r;
   assign rxLinkRst = ~rxRstOff_r;
   assign rxCountEn = rxEn_r;
   assign txClkEn = txEn_r;

   // command bus driver; grant flags the sent command to the link logic
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         dpValid_r <= 1'b0;
         dpCmd_r <= DP_CMD_IDLE;
         dpCpu_r <= 1'b0;
      end else begin
         dpValid_r <= |grant;
         dpCmd_r <= (|grant) ? DP_CMD_TOGGLE_LINK : DP_CMD_IDLE;
         dpCpu_r <= grant[1];
      end
   end

   assign dpCmdValid = dpValid_r;
   assign dpCmd = dpCmd_r;
   assign dpCmdCpu = dpCpu_r;

   assign modeHit = regAddr[ADDR_W-1:MODE_IDX_LSB+2] == REG_MODE_PROG0[ADDR_W-1:MODE_IDX_LSB+2]
                    && regAddr[MODE_IDX_LSB-1:0] == 2'h0;
   assign modeIdx = regAddr[MODE_IDX_LSB +: 2];

   // refresh stays off from reset until firmware writes an interval
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         refInterval_r <= 8'h00;
      end else if (regWr && regAddr == REG_MEM_TIMING) begin
         refInterval_r <= regWrData[7:0];
      end
   end

   assign refLimit = {refInterval_r, {REF_SHIFT{1'b0}}};

   // a refresh due while another command goes out waits in refPend_r
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         refCnt_r <= 12'h000;
         refPend_r <= 1'b0;
      end else begin
         if (refInterval_r == 8'h00) begin
            refCnt_r <= 12'h000;
         end else if (refCnt_r >= refLimit - 12'h001) begin
            refCnt_r <= 12'h000;
         end else begin
            refCnt_r <= refCnt_r + 12'h001;
         end
         if (refInterval_r != 8'h00 && refCnt_r >= refLimit - 12'h001) begin
            refPend_r <= 1'b1;
         end else if (pchgDone_r && !mrsAny) begin
            refPend_r <= 1'b0;
         end
      end
   end

   // lowest pending array goes first
   always_comb begin
      mrsIdx = 2'h0;
      for (int i = NUM_ARRAY - 1; i >= 0; i--) begin
         if (mrsPend_r[i]) begin
            mrsIdx = 2'(i);
         end
      end
   end

   assign mrsAny = |mrsPend_r;

   // a new write sets its pending bit even in the cycle it would be cleared
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         mrsPend_r <= '0;
         for (int i = 0; i < NUM_ARRAY; i++) begin
            modeVal_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_ARRAY; i++) begin
            if (regWr && modeHit && modeIdx == 2'(i)) begin
               mrsPend_r[i] <= 1'b1;
               modeVal_r[i] <= regWrData[SD_ADDR_W-1:0];
            end else if (pchgDone_r && mrsAny && mrsIdx == 2'(i)) begin
               mrsPend_r[i] <= 1'b0;
            end
         end
      end
   end

   // reset shows masks high and a no-op; precharge-all goes out first after release
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         pchgDone_r <= 1'b0;
         sdCmd_r <= SD_NOP;
         sdSel_r <= '0;
         sdAddr_r <= '0;
         sdDqm_r <= 2'h3;
      end else begin
         sdCmd_r <= SD_NOP;
         sdSel_r <= '0;
         sdAddr_r <= '0;
         if (!pchgDone_r) begin
            pchgDone_r <= 1'b1;
            sdCmd_r <= SD_PRECHARGE;
            sdSel_r <= '1;
            sdAddr_r[PCHG_ADDR_BIT] <= 1'b1;
         end else if (mrsAny) begin
            sdCmd_r <= SD_MODE_SET;
            sdSel_r <= NUM_ARRAY'(1) << mrsIdx;
            sdAddr_r <= modeVal_r[mrsIdx];
            sdDqm_r <= 2'h0;
         end else if (refPend_r) begin
            sdCmd_r <= SD_REFRESH;
            sdSel_r <= '1;
            sdDqm_r <= 2'h0;
         end
      end
   end

   assign sdramCmd = sdCmd_r;
   assign sdramSel = sdSel_r;
   assign sdramAddr = sdAddr_r;
   assign sdramDqm = sdDqm_r;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge sysRstInt_n) begin
      if (!sysRstInt_n) begin
         rdData_r <= '0;
      end else begin
         rdData_r <= '0;
         if (regRd) begin
            if (regAddr == REG_STRAP) begin
               rdData_r <= {24'h000000, strap_r};
            end else if (regAddr == REG_LINK) begin
               rdData_r <= {24'h000000, txEn_r, rxEn_r, rxRstOff_r, linkRst_r};
            end else if (regAddr == REG_MEM_TIMING) begin
               rdData_r <= {24'h000000, refInterval_r};
            end else if (regAddr == REG_CFG_DRIVE) begin
               rdData_r <= {23'h000000, cfgOe_r, cfgOut_r};
            end else if (modeHit) begin
               rdData_r <= {18'h00000, modeVal_r[modeIdx]};
            end
         end
      end
   end

   assign regRdData = rdData_r;
endmodule : reset_init_seq
`default_nettype wire

// File: bench/reset_init_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module reset_init_seq_props
   import reset_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sysRstA_n,
   input wire logic sysRstB_n,
   input wire logic sysRstC_n,
   input wire logic sysRstInt_n,
   input wire logic [7:0] cfgBusDataIn,
   input wire logic cfgBusDataOe,
   input wire logic fillDelay,
   input wire logic [1:0] fillDelayCyc,
   input wire logic [2:0] extractDelayCyc,
   input wire logic [1:0] linkPreset,
   input wire logic [1:0] baseConfig,
   input wire logic moduleSpare,
   input wire logic [1:0] bootRomEn_n,
   input wire logic [1:0] linkRst,
   input wire logic [1:0] rxLinkRst,
   input wire logic [1:0] rxCountEn,
   input wire logic [1:0] txClkEn,
   input wire logic dpCmdValid,
   input wire logic [1:0] dpCmd,
   input wire logic dpCmdCpu,
   input wire logic [2:0] sdramCmd,
   input wire logic [3:0] sdramSel,
   input wire logic [13:0] sdramAddr,
   input wire logic [1:0] sdramDqm,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_copy;
      $rose(rst_n) |-> (!sysRstA_n && !sysRstB_n && !sysRstC_n) [*3]
         ##1 (sysRstA_n && sysRstB_n && sysRstC_n);
   endproperty
   property p_int;
      $rose(rst_n) |-> !sysRstInt_n [*5] ##1 sysRstInt_n;
   endproperty
   property p_hold;
      !sysRstInt_n |-> linkRst == 2'b11 && !cfgBusDataOe && sdramDqm == 2'b11 && sdramCmd == SD_NOP;
   endproperty
   // straps are only valid while the board still holds them, one edge after release
   property p_strap;
      $rose(sysRstInt_n) |=> {moduleSpare, fillDelay, fillDelayCyc, extractDelayCyc, linkPreset,
         baseConfig} == {cfgBusDataIn[7:6], 2'h2 + {1'b0, cfgBusDataIn[6]},
         3'h2 + {1'b0, cfgBusDataIn[5:4]}, cfgBusDataIn[3:0]};
   endproperty
   property p_prech;
      $rose(sysRstInt_n) |=> sdramCmd == SD_PRECHARGE && sdramAddr[PCHG_ADDR_BIT] ##1 sdramCmd == SD_NOP;
   endproperty
   property p_notify;
      $fell(bootRomEn_n[0]) |=> !linkRst[0] [*2] ##1 linkRst[0];
   endproperty
   // own receiver trails the CPU release by one cycle, well inside the CPU's start-up
   property p_toggle;
      dpCmdValid && !dpCmdCpu |-> dpCmd == DP_CMD_TOGGLE_LINK && linkRst[0] && rxLinkRst[0]
         ##1 !linkRst[0] && rxLinkRst[0] ##1 !rxLinkRst[0];
   endproperty
   property p_recv;
      (rxLinkRst & (rxCountEn | txClkEn)) == 2'b00;
   endproperty
   property p_tx;
      $rose(rxCountEn[0]) |-> !txClkEn[0] [*4] ##1 txClkEn[0];
   endproperty
   property p_mode;
      regWr && sysRstInt_n && regAddr[7:4] == 4'h1 && regAddr[1:0] == 2'h0 |=> ##1
         sdramCmd == SD_MODE_SET && sdramSel == 4'h1 << $past(regAddr[3:2], 2)
         && sdramAddr == $past(regWrData[13:0], 2);
   endproperty
   a_copy: assert property (p_copy) else $error("reset copy release timing");
   a_int: assert property (p_int) else $error("internal reset release timing");
   a_hold: assert property (p_hold) else $error("outputs not held in reset");
   a_strap: assert property (p_strap) else $error("strap capture wrong");
   a_prech: assert property (p_prech) else $error("no precharge on release");
   a_notify: assert property (p_notify) else $error("notify pulse wrong");
   a_toggle: assert property (p_toggle) else $error("toggle release wrong");
   a_recv: assert property (p_recv) else $error("link active in reset");
   a_tx: assert property (p_tx) else $error("transmit start delay wrong");
   a_mode: assert property (p_mode) else $error("mode set wrong");
   c_cpu1: cover property (dpCmdValid && dpCmdCpu);
   c_refresh: cover property (sdramCmd == SD_REFRESH);
   c_tx: cover property (txClkEn == 2'b11);
endmodule : reset_init_seq_props
bind reset_init_seq reset_init_seq_props i_props (.ref_clk, .rst_n, .sysRstA_n, .sysRstB_n,
   .sysRstC_n, .sysRstInt_n, .cfgBusDataIn, .cfgBusDataOe, .fillDelay, .fillDelayCyc,
   .extractDelayCyc, .linkPreset, .baseConfig, .moduleSpare, .bootRomEn_n, .linkRst, .rxLinkRst,
   .rxCountEn, .txClkEn, .dpCmdValid, .dpCmd, .dpCmdCpu, .sdramCmd, .sdramSel, .sdramAddr,
   .sdramDqm, .regAddr, .regWrData, .regWr);
`default_nettype wire

// File: bench/cpu_boot_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_boot_model #(
   parameter int READY_CYC = 8,
   parameter int LOAD_CYC = 20
) (
   input wire logic ref_clk,
   input wire logic sysRstA_n,
   output logic bootRomEn_n
);
   int cnt;
   // enable is a level held for the whole boot load, then dropped for good
   always_ff @(posedge ref_clk or negedge sysRstA_n) begin
      if (!sysRstA_n) begin
         cnt <= 0;
         bootRomEn_n <= 1'b1;
      end else begin
         if (cnt < READY_CYC + LOAD_CYC) begin
            cnt <= cnt + 1;
         end
         bootRomEn_n <= !(cnt >= READY_CYC && cnt < READY_CYC + LOAD_CYC);
      end
   end
endmodule : cpu_boot_model
`default_nettype wire

// File: bench/reset_init_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_init_seq_tb;
   import reset_seq_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic frameTick = 1'b0;
   logic dpBusBusy = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] cfgBusDataIn = 8'h00;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h00000000;
   logic [1:0] frameCnt = 2'h0;
   wire logic [1:0] bootRomEn_n;
   logic sysRstA_n, sysRstB_n, sysRstC_n, sysRstInt_n, cfgBusDataOe, fillDelay;
   logic moduleSpare, dpCmdValid, dpCmdCpu;
   logic [1:0] fillDelayCyc, linkPreset, baseConfig, linkRst, rxLinkRst;
   logic [1:0] rxCountEn, txClkEn, dpCmd, sdramDqm;
   logic [2:0] extractDelayCyc, sdramCmd;
   logic [3:0] sdramSel;
   logic [7:0] cfgBusDataOut;
   logic [13:0] sdramAddr;
   logic [31:0] regRdData, rd;
   int n_mismatch = 0;
   int tests_run = 0;
   int n;

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      frameCnt <= frameCnt + 2'h1;
      frameTick <= (frameCnt == 2'h3);
   end

   reset_init_seq i_dut (.ref_clk, .rst_n, .sysRstA_n, .sysRstB_n, .sysRstC_n, .sysRstInt_n,
      .cfgBusDataIn, .cfgBusDataOut, .cfgBusDataOe, .fillDelay, .fillDelayCyc, .extractDelayCyc,
      .linkPreset, .baseConfig, .moduleSpare, .bootRomEn_n, .linkRst, .frameTick, .rxLinkRst,
      .rxCountEn, .txClkEn, .dpBusBusy, .dpCmdValid, .dpCmd, .dpCmdCpu, .sdramCmd, .sdramSel,
      .sdramAddr, .sdramDqm, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
   cpu_boot_model #(.LOAD_CYC(20)) i_cpu0 (.ref_clk, .sysRstA_n, .bootRomEn_n(bootRomEn_n[0]));
   cpu_boot_model #(.LOAD_CYC(24)) i_cpu1 (.ref_clk, .sysRstA_n, .bootRomEn_n(bootRomEn_n[1]));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : check

   task automatic step;
      @(posedge ref_clk);
      #1;
      n++;
   endtask : step

   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask : regRead

   task automatic countRefresh(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge ref_clk);
         #1;
         if (sdramCmd === SD_REFRESH) c++;
      end
   endtask : countRefresh

   // reset is held only 6 cycles here; the board holds it far longer
   task automatic phase(input logic [7:0] s);
      @(posedge ref_clk);
      cfgBusDataIn <= s;
      dpBusBusy <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      n = 0;
      while (sysRstInt_n !== 1'b1 && n < 9) step();
      check(n, 5, "release latency");
      step();
      rd = {moduleSpare, fillDelay, fillDelayCyc, extractDelayCyc, linkPreset, baseConfig};
      check(rd, {s[7:6], 2'h2 + {1'b0, s[6]}, 3'h2 + {1'b0, s[5:4]}, s[3:0]}, "straps");
      check({sdramCmd, sdramSel, sdramAddr[10]}, {SD_PRECHARGE, 4'hF, 1'b1}, "precharge");
      n = 0;
      while (bootRomEn_n !== 2'b00 && n < 40) step();
      step();
      check(linkRst, 2'b00, "notch");
      repeat (3) step();
      check(linkRst, 2'b11, "notch over");
      while (bootRomEn_n !== 2'b11 && n < 80) step();
      // other issuer owns the command bus, so both toggles must wait
      repeat (4) begin
         step();
         check(dpCmdValid, 1'b0, "stalled");
      end
      @(posedge ref_clk);
      dpBusBusy <= 1'b0;
      n = 0;
      while (dpCmdValid !== 1'b1 && n < 6) step();
      check({dpCmd, dpCmdCpu}, {DP_CMD_TOGGLE_LINK, 1'b0}, "first toggle");
      step();
      check(linkRst[0], 1'b0, "cpu0 release");
      n = 0;
      while (!(dpCmdValid === 1'b1 && dpCmdCpu === 1'b1) && n < 6) step();
      check(n < 6, 1'b1, "second toggle");
      n = 0;
      while (txClkEn !== 2'b11 && n < 40) step();
      check({linkRst, rxLinkRst, rxCountEn, txClkEn}, 8'h0F, "links up");
      regRead(REG_LINK, rd);
      check(rd, 32'hFC, "link reg");
      $display("test phase %0h done", s);
   endtask : phase

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   initial begin
      phase(8'hB6);
      regRead(REG_STRAP, rd);
      check(rd, 32'hB6, "strap reg");
      regRead(8'h40, rd);
      check(rd, 32'h0, "unmapped");
      regWrite(REG_CFG_DRIVE, 32'h1A5);
      #1;
      check({cfgBusDataOe, cfgBusDataOut}, 9'h1A5, "cfg drive");
      countRefresh(100, n);
      check(n, 0, "refresh off");
      regWrite(REG_MEM_TIMING, 32'h4);
      countRefresh(600, n);
      check(n >= 8, 1'b1, "refresh on");
      regWrite(REG_MEM_TIMING, 32'h0);
      countRefresh(70, n);
      countRefresh(200, n);
      check(n, 0, "refresh stopped");
      for (int k = 0; k < 4; k++) begin
         regWrite(REG_MODE_PROG0 + 8'(4 * k), 32'h30 + k);
         // pending bit lands with the write; the command leaves one edge later
         step();
         rd = {sdramCmd, sdramSel, sdramAddr, sdramDqm};
         check(rd, {SD_MODE_SET, 4'h1 << k, 14'(48 + k), 2'b00}, "mode set");
      end
      $display("test registers done");
      @(posedge ref_clk);
      rst_n <= 1'b0;
      #1;
      rd = {sysRstA_n, sysRstB_n, sysRstC_n, sysRstInt_n, cfgBusDataOe, linkRst};
      check(rd, 7'h03, "async reset");
      phase(8'h49);
      conclude();
   end

   // whole run is near 1100 cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end
endmodule : reset_init_seq_tb
`default_nettype wire
